// ==== rtl/rsx_defs.svh ====
// Constants for the return stack instruction execution block
`ifndef RSX_DEFS_SVH
`define RSX_DEFS_SVH

`define RSX_OP_DISCARD   16'h0006
`define RSX_OP_SAVE      16'h0005
`define RSX_OP_SWRESET   16'h00FF
`define RSX_OP_RETURN_HI 15'h0009
`define RSX_RELATIVE_SUBROUTINE_CALL_TOP    5'h1B
`define RSX_PC_STEP      21'h00_0002
`define RSX_PC_RESET     21'h00_0000
`define RSX_QPHASES      2'h3

`endif

// ==== rtl/rsx_exec.sv ====
// Execution of discard, save, relative call, return and software reset
`include "rsx_defs.svh"
module rsx_exec
	import rsx_pkg::*;
#(
	parameter int AW    = 21,
	parameter int DEPTH = 31
) (
	input  wire logic          clk_i,
	input  wire logic          resetn_i,
	input  wire logic [15:0]   instr_i,
	input  wire logic          instr_valid_i,
	input  wire logic          head_write_i,
	input  wire logic [AW-1:0] head_data_i,
	output logic      [AW-1:0] pc_o,
	output logic      [AW-1:0] stack_head_value_o,
	output logic               flush_o,
	output logic               soft_reset_o,
	output logic      [1:0]    qphase_o
);
	initial begin
		if (AW < 12) $error("rsx_exec: AW too small");
	end

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	rsx_state_type  state_q;
	logic [AW-1:0]  pc_q;
	logic           reset_req_q;
	wire logic      exec_ok;
	wire logic      is_discard;
	wire logic      is_save;
	wire logic      is_call;
	wire logic      is_ret;
	wire logic      is_swreset;
	wire logic [AW-1:0] pc_next;
	wire logic [AW-1:0] pc_target;

	assign exec_ok    = instr_valid_i && state_q == RSX_EXEC && !reset_req_q;
	assign is_discard = exec_ok && instr_i == `RSX_OP_DISCARD;
	assign is_save    = exec_ok && instr_i == `RSX_OP_SAVE;
	assign is_call    = exec_ok && instr_i[15:11] == `RSX_RELATIVE_SUBROUTINE_CALL_TOP;
	assign is_ret     = exec_ok && instr_i[15:1] == `RSX_OP_RETURN_HI;
	assign is_swreset = exec_ok && instr_i == `RSX_OP_SWRESET;

	rsx_stack_if #(.AW(AW)) st ();

	rsx_pcadd #(.AW(AW)) u_add (
		.base_i    (pc_q),
		.off_i     (instr_i[10:0]),
		.use_off_i (is_call),
		.next_o    (pc_next),
		.target_o  (pc_target)
	);

	// ----------------------------------------
	// Stack control
	// ----------------------------------------
	assign st.push       = is_save || is_call;
	assign st.pop        = is_discard || is_ret;
	assign st.write_head = head_write_i && !st.push && !st.pop;
	assign st.push_data  = st.push ? pc_next : head_data_i;
	assign st.clear      = reset_req_q;

	rsx_stack #(.AW(AW), .DEPTH(DEPTH)) u_stack (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.st       (st)
	);

	// ----------------------------------------
	// Program counter and sequencing
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (!resetn_i || reset_req_q) begin
			pc_q        <= AW'(`RSX_PC_RESET);
			state_q     <= RSX_EXEC;
			reset_req_q <= 1'b0;
			flush_o     <= 1'b0;
		end else begin
			reset_req_q <= is_swreset;
			flush_o     <= is_call || is_ret;
			if (is_call) begin
				pc_q    <= {pc_target[AW-1:1], 1'b0};
				state_q <= RSX_FLUSH;
			end else if (is_ret) begin
				pc_q    <= {st.head[AW-1:1], 1'b0};
				state_q <= RSX_FLUSH;
			end else if (state_q == RSX_FLUSH) begin
				state_q <= RSX_EXEC;
			end else if (exec_ok) begin
				pc_q <= {pc_next[AW-1:1], 1'b0};
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			qphase_o           <= 2'h0;
			stack_head_value_o <= '0;
			soft_reset_o       <= 1'b0;
		end else begin
			qphase_o           <= qphase_o + 2'h1;
			stack_head_value_o <= st.head;
			soft_reset_o       <= is_swreset;
		end
	end
	assign pc_o = pc_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_call;
		is_call;
	endsequence
	sequence s_flush_then_run;
		state_q == RSX_FLUSH ##1 state_q == RSX_EXEC;
	endsequence

	AST_CALL_TWO_CYCLE: assert property (@(posedge clk_i) disable iff (!resetn_i)
		s_call |=> s_flush_then_run) else $error("call not two cycles");
	AST_CALL_TARGET: assert property (@(posedge clk_i) disable iff (!resetn_i)
		is_call && !reset_req_q |=> pc_q == $past(pc_target)) else $error("call target wrong");
	AST_CALL_PUSH: assert property (@(posedge clk_i) disable iff (!resetn_i)
		is_call |=> st.head == $past(pc_next)) else $error("call return address wrong");
	AST_SAVE_PUSH: assert property (@(posedge clk_i) disable iff (!resetn_i)
		is_save |=> st.head == $past(pc_q) + AW'(2)) else $error("save value wrong");
	AST_PC_EVEN: assert property (@(posedge clk_i) disable iff (!resetn_i)
		pc_q[0] == 1'b0) else $error("pc odd");
	AST_PC_STEP: assert property (@(posedge clk_i) disable iff (!resetn_i)
		exec_ok && !is_call && !is_ret && !is_swreset |=> pc_q == $past(pc_q) + AW'(2))
		else $error("pc step wrong");
	AST_SWRESET: assert property (@(posedge clk_i) disable iff (!resetn_i)
		is_swreset |=> ##1 pc_q == '0 && state_q == RSX_EXEC) else $error("soft reset failed");
	AST_RETURN: assert property (@(posedge clk_i) disable iff (!resetn_i)
		is_ret |=> pc_q == {$past(st.head[AW-1:1]), 1'b0}) else $error("return pc wrong");
	AST_DISCARD: assert property (@(posedge clk_i) disable iff (!resetn_i)
		is_discard |=> state_q == RSX_EXEC) else $error("discard not one cycle");

	// ----------------------------------------
	// Pulse and sequencing checks
	// ----------------------------------------
	sequence s_flush_pulse;
		flush_o ##1 !flush_o;
	endsequence
	sequence s_soft_pulse;
		soft_reset_o ##1 !soft_reset_o;
	endsequence

	AST_FLUSH_PULSE: assert property (@(posedge clk_i) disable iff (!resetn_i)
		is_call || is_ret |=> s_flush_pulse) else $error("flush pulse wrong");
	AST_FLUSH_HOLD: assert property (@(posedge clk_i) disable iff (!resetn_i)
		state_q == RSX_FLUSH |=> pc_q == $past(pc_q)) else $error("pc moved in flush");
	AST_RET_FLUSH: assert property (@(posedge clk_i) disable iff (!resetn_i)
		is_ret |=> state_q == RSX_FLUSH) else $error("return not two cycles");
	AST_PLAIN_NO_FLUSH: assert property (@(posedge clk_i) disable iff (!resetn_i)
		is_discard || is_save |=> !flush_o) else $error("plain op flushed");
	AST_SAVE_ONE_CYCLE: assert property (@(posedge clk_i) disable iff (!resetn_i)
		is_save |=> state_q == RSX_EXEC) else $error("save not one cycle");
	AST_SOFT_PULSE: assert property (@(posedge clk_i) disable iff (!resetn_i)
		is_swreset |=> s_soft_pulse) else $error("soft reset pulse wrong");
	AST_SOFT_CLEAR: assert property (@(posedge clk_i) disable iff (!resetn_i)
		reset_req_q |=> st.head == '0 && pc_q == '0 && !flush_o)
		else $error("soft reset left state");
	AST_HEAD_WRITE: assert property (@(posedge clk_i) disable iff (!resetn_i)
		st.write_head && st.head != '0 && !reset_req_q |=> st.head == $past(st.push_data))
		else $error("head write lost");
	AST_HEAD_COPY: assert property (@(posedge clk_i) disable iff (!resetn_i)
		$past(resetn_i) |-> stack_head_value_o == $past(st.head))
		else $error("head copy stale");
	AST_QPHASE_STEP: assert property (@(posedge clk_i) disable iff (!resetn_i)
		$past(resetn_i) |-> qphase_o == $past(qphase_o) + 2'h1)
		else $error("quarter phase skipped");
endmodule // rsx_exec

// ==== rtl/rsx_pcadd.sv ====
// Program counter adder: base plus step plus doubled signed offset
`include "rsx_defs.svh"
module rsx_pcadd #(
	parameter int AW = 21
) (
	input  wire logic [AW-1:0] base_i,
	input  wire logic [10:0]   off_i,
	input  wire logic          use_off_i,
	output wire logic [AW-1:0] next_o,
	output wire logic [AW-1:0] target_o
);
	wire logic [AW-1:0] off2;
	assign off2     = use_off_i ? AW'({{(AW-11){off_i[10]}}, off_i, 1'b0} ) : '0;
	assign next_o   = base_i + AW'(`RSX_PC_STEP);
	assign target_o = next_o + off2;
endmodule // rsx_pcadd

// ==== rtl/rsx_pkg.sv ====
// Types for the return stack instruction execution block
package rsx_pkg;
	typedef enum logic [1:0] {
		RSX_OP_NONE_TYPE_UNUSED_IS_NOT_ALLOWED = 2'h0
	} rsx_unused_type;
	typedef enum {
		RSX_EXEC,
		RSX_FLUSH
	} rsx_state_type;
endpackage

// ==== rtl/rsx_stack.sv ====
// Return stack storage in flip-flops
module rsx_stack #(
	parameter int AW    = 21,
	parameter int DEPTH = 31
) (
	input  wire logic       clk_i,
	input  wire logic       resetn_i,
	rsx_stack_if.store      st
);
	localparam int PW = $clog2(DEPTH + 1);
	logic [AW-1:0] mem_q [DEPTH];
	logic [PW-1:0] ptr_q;
	initial begin
		if (DEPTH < 2) $error("rsx_stack: DEPTH too small");
	end
	assign st.head = (ptr_q == '0) ? '0 : mem_q[ptr_q - PW'(1)];
	always_ff @(posedge clk_i) begin
		if (!resetn_i || st.clear) begin
			ptr_q <= '0;
		end else if (st.push && ptr_q != PW'(DEPTH)) begin
			mem_q[ptr_q] <= st.push_data;
			ptr_q        <= ptr_q + PW'(1);
		end else if (st.pop && ptr_q != '0) begin
			ptr_q <= ptr_q - PW'(1);
		end else if (st.write_head && ptr_q != '0) begin
			mem_q[ptr_q - PW'(1)] <= st.push_data;
		end
	end
endmodule // rsx_stack

// ==== rtl/rsx_stack_if.sv ====
// Stack port carried between the executor and the stack store
interface rsx_stack_if #(parameter int AW = 21);
	logic          push;
	logic          pop;
	logic          write_head;
	logic [AW-1:0] push_data;
	logic [AW-1:0] head;
	logic          clear;
	modport exec  (output push, pop, write_head, push_data, clear, input head);
	modport store (input push, pop, write_head, push_data, clear, output head);
endinterface

// ==== testbench/rsx_fetch_model.sv ====
// Fetch stage model presenting one instruction word per request
module rsx_fetch_model (
	input  wire logic        clk_i,
	input  wire logic        req_i,
	input  wire logic [15:0] op_i,
	output logic      [15:0] instr_o,
	output logic             valid_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        req_s;
	logic [15:0] op_s;
	initial begin
		instr_o = 16'h0000;
		valid_o = 1'b0;
	end
	// Word stands one cycle; outside it the bus toggles, never stale
	always @(posedge clk_i) begin
		req_s = req_i;
		op_s = op_i;
		#1;
		valid_o = req_s;
		instr_o = req_s ? op_s : ~instr_o;
	end
endmodule // rsx_fetch_model

// ==== testbench/tb.sv ====
// Self-checking bench for the return stack executor
`include "rsx_defs.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, resetn, req, hwr, valid, flush, sreset;
	logic [15:0] op, instr;
	logic [1:0]  qph;
	logic [20:0] hdata, pc, head, pexp, p;
	int          miscompares, total_checks;
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	rsx_fetch_model u_rsx_fetch_model (.clk_i(clk), .req_i(req), .op_i(op),
		.instr_o(instr), .valid_o(valid));
	rsx_exec u_rsx_exec (.clk_i(clk), .resetn_i(resetn), .instr_i(instr),
		.instr_valid_i(valid), .head_write_i(hwr), .head_data_i(hdata), .pc_o(pc),
		.stack_head_value_o(head), .flush_o(flush), .soft_reset_o(sreset), .qphase_o(qph));
	// ----------
	// Tasks
	// ----------
	task automatic check(input logic [20:0] seen, input logic [20:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick;
		@(posedge clk);
		#1;
	endtask
	task automatic exec(input logic [15:0] w);
		req = 1'b1;
		op = w;
		tick;
		req = 1'b0;
		tick;
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// ----------
	// Scenarios
	// ----------
	task automatic t_stack;
		exec(`RSX_OP_SAVE);
		check(pc, 21'h0_0002);
		tick;
		check(head, 21'h0_0002);
		exec(`RSX_OP_SAVE);
		tick;
		check(head, 21'h0_0004);
		exec(`RSX_OP_DISCARD);
		check(21'(flush), 21'h0_0000);
		check(pc, 21'h0_0006);
		tick;
		check(head, 21'h0_0002);
		pexp = 21'h0_0006;
		$display("test stack done");
	endtask
	task automatic t_head;
		hwr = 1'b1;
		hdata = 21'h0_1234;
		tick;
		hwr = 1'b0;
		tick;
		check(head, 21'h0_1234);
		exec(`RSX_OP_SAVE);
		pexp = pexp + 21'h0_0002;
		tick;
		check(head, pexp);
		exec(`RSX_OP_DISCARD);
		pexp = pexp + 21'h0_0002;
		tick;
		check(head, 21'h0_1234);
		$display("test head done");
	endtask
	task automatic t_call;
		p = pexp;
		exec({`RSX_RELATIVE_SUBROUTINE_CALL_TOP, 11'h400});
		check(pc, p + 21'h0_0002 - 21'h0_0800);
		check(21'(flush), 21'h0_0001);
		tick;
		check(21'(flush), 21'h0_0000);
		check(head, p + 21'h0_0002);
		exec({`RSX_OP_RETURN_HI, 1'b0});
		check(pc, p + 21'h0_0002);
		tick;
		tick;
		check(head, 21'h0_1234);
		p = p + 21'h0_0002;
		exec({`RSX_RELATIVE_SUBROUTINE_CALL_TOP, 11'h3FF});
		check(pc, p + 21'h0_0800);
		$display("test call done");
	endtask
	task automatic t_reset;
		tick;
		exec(`RSX_OP_SWRESET);
		check(21'(sreset), 21'h0_0001);
		tick;
		tick;
		check(pc, 21'h0_0000);
		check(head, 21'h0_0000);
		$display("test reset done");
	endtask
	task automatic t_hwreset;
		exec(`RSX_OP_SAVE);
		resetn = 1'b0;
		tick;
		tick;
		resetn = 1'b1;
		check(pc, 21'h0_0000);
		check(head, 21'h0_0000);
		check(21'(qph), 21'h0_0000);
		tick;
		check(21'(qph), 21'h0_0001);
		exec(`RSX_OP_SAVE);
		check(pc, 21'h0_0002);
		$display("test hwreset done");
	endtask
	initial begin
		{resetn, req, hwr} = 3'h0;
		op = 16'h0000;
		hdata = 21'h0_0000;
		miscompares = 0;
		total_checks = 0;
		repeat (10) @(posedge clk);
		#1 resetn = 1'b1;
		t_stack;
		t_head;
		t_call;
		t_reset;
		t_hwreset;
		results;
	end
	initial begin
		repeat (2000) @(posedge clk);
		miscompares++;
		results;
	end
endmodule // tb
